// [ptpwm_pkg.sv]
/*
 * Constants, field layouts and carrier types shared by the period timer
 * and PWM time base and by its prescale helper.
 * Assumes a single system clock; the instruction rate is one quarter of it.
 */
`default_nettype none

package ptpwm_pkg;

    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // register offsets on the plain register port
    localparam logic [2:0] OFS_COUNTER  = 3'h0;
    localparam logic [2:0] OFS_LIMIT    = 3'h1;
    localparam logic [2:0] OFS_CONTROL  = 3'h2;
    localparam logic [2:0] OFS_DUTY_LOW = 3'h3;
    localparam logic [2:0] OFS_PWM_CTL  = 3'h4;
    localparam logic [2:0] OFS_SHADOW   = 3'h5;
    localparam logic [2:0] OFS_FLAGS    = 3'h6;
    localparam logic [2:0] OFS_MASK     = 3'h7;

    // reset values
    localparam logic [7:0] COUNTER_RESET = 8'h00;
    localparam logic [7:0] LIMIT_RESET   = 8'hFF;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] PWM_CTL_RESET = 8'h00;
    localparam logic [7:0] DUTY_RESET    = 8'h00;
    localparam logic [7:0] FLAGS_RESET   = 8'h00;
    localparam logic [7:0] MASK_RESET    = 8'h00;
    localparam logic [1:0] FRAC_RESET    = 2'h0;
    localparam logic [3:0] SCALE_RESET   = 4'h0;

    // implemented bits of each register, others read as zero
    localparam logic [7:0] CONTROL_MASK = 8'h7F;
    localparam logic [7:0] PWM_CTL_MASK = 8'h3F;
    localparam logic [7:0] FLAGS_MASK   = 8'h02;

    // field positions
    localparam int FLAG_MATCH_BIT = 1;
    localparam logic [1:0] PWM_MODE_CODE = 2'h3;

    // quarter-cycle phase and prescaler terminal counts
    localparam logic [1:0] QUARTER_LAST  = 2'h3;
    localparam logic [3:0] PRE_LAST_DIV1  = 4'h0;
    localparam logic [3:0] PRE_LAST_DIV4  = 4'h3;
    localparam logic [3:0] PRE_LAST_DIV16 = 4'hF;

    typedef enum logic [1:0] {
        PTPWM_DIV1,
        PTPWM_DIV4,
        PTPWM_DIV16
    } ptpwm_div_type;

    typedef struct packed {
        logic                wr;
        logic                rd;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } ptpwm_bus_type;

    typedef struct packed {
        logic       spare;
        logic [3:0] postscale_select;
        logic       timer_run;
        logic [1:0] prescale_select;
    } ptpwm_ctrl_type;

    typedef struct packed {
        logic [1:0] spare;
        logic       duty_fraction_bit_hi;
        logic       duty_fraction_bit_lo;
        logic [1:0] mode_hi;
        logic [1:0] mode_lo;
    } ptpwm_unit_type;

    function automatic ptpwm_div_type ptpwm_decode_div(
        input logic [1:0] sel
    );
        ptpwm_div_type d;
        if (sel[1])
            d = PTPWM_DIV16;
        else if (sel[0])
            d = PTPWM_DIV4;
        else
            d = PTPWM_DIV1;
        return d;
    endfunction

    function automatic logic [3:0] ptpwm_div_last(
        input ptpwm_div_type d
    );
        logic [3:0] last;
        case (d)
            PTPWM_DIV4:  last = PRE_LAST_DIV4;
            PTPWM_DIV16: last = PRE_LAST_DIV16;
            default:     last = PRE_LAST_DIV1;
        endcase
        return last;
    endfunction

endpackage

`default_nettype wire

// [ptpwm_prescale.sv]
/*
 * Quarter-cycle phase and selectable prescaler of the period timer.
 * Assumes the clear input is a one-cycle strobe from the register logic.
 */
`timescale 1ns/1ns
`default_nettype none

module ptpwm_prescale
    import ptpwm_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       nrst_i,
    input  wire logic       clear_i,
    input  wire logic       run_i,
    input  wire logic [1:0] select_i,
    output logic            tick_o,
    output logic [1:0]      frac_o
);

    logic [1:0]    quarter_reg;
    logic [3:0]    pre_reg;
    ptpwm_div_type div;
    logic          instr_tick;

    assign div        = ptpwm_decode_div(select_i);      // see R2
    assign instr_tick = (quarter_reg == QUARTER_LAST);   // see R1

    // the phase runs free; only the prescale count is cleared
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            quarter_reg <= FRAC_RESET;
        else
            quarter_reg <= quarter_reg + 2'h1;
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pre_reg <= SCALE_RESET;
        else if (clear_i)
            pre_reg <= SCALE_RESET;                      // see R7
        else if (run_i && instr_tick)
        begin
            if (pre_reg >= ptpwm_div_last(div))
                pre_reg <= SCALE_RESET;
            else
                pre_reg <= pre_reg + 4'h1;
        end
    end

    assign tick_o = run_i && !clear_i && instr_tick
                    && (pre_reg >= ptpwm_div_last(div)); // see R1

    // two extra duty bits below the counter, see R12
    always_comb
    begin
        case (div)
            PTPWM_DIV4:  frac_o = pre_reg[1:0];
            PTPWM_DIV16: frac_o = pre_reg[3:2];
            default:     frac_o = quarter_reg;
        endcase
    end

endmodule

`default_nettype wire

// [ptpwm_timer.sv]
/*
 * Period timer with prescaler, postscaler, match interrupt and a
 * single-channel PWM that uses the timer as its time base.
 * Assumes a register master on the plain port that holds each strobe for
 * one cycle, never raises both strobes together and takes read data in
 * the cycle after the read strobe.
 */
// Behaviour
// R1 - counter ticks at quarter clock rate divided by one, four or sixteen
// R2 - prescale code 00 divides by one, 01 by four, 1x by sixteen
// R3 - counter matches pass a 4-bit postscaler that sets the match flag
// R4 - postscale ratio equals the four-bit select value plus one
// R5 - reset clears the counter and loads the period limit with all ones
// R6 - counter and period limit are readable and writable at any time
// R7 - counter write, control write or reset clear prescale and postscale
// R8 - a control write leaves the counter value unchanged
// R9 - control bit 2 runs the timer; bit 7 always reads zero
// R10 - timer serves as the period time base in PWM mode
// R11 - duty is double buffered in shadow byte plus 2-bit latch
// R12 - pin clears when buffered 10-bit duty equals counter with low bits
// R13 - duty beyond the period never clears the pin that period
// R14 - software sets period, duty, pin direction, timer, then PWM mode
// R15 - counter increments per tick and wraps to zero after equalling limit
// R16 - on period match pin goes high unless duty zero; duty reloads
`timescale 1ns/1ns
`default_nettype none

module ptpwm_timer
    import ptpwm_pkg::*;
(
    input  wire logic          clock_i,
    input  wire logic          nrst_i,
    input  wire ptpwm_bus_type bus_i,
    output logic [7:0]         rdata_o,
    output logic               irq_o,
    output logic               match_pulse_o,
    output logic               pwm_output_pin_o,
    output logic               pwm_mode_o
);

    logic [7:0]     period_counter_reg;
    logic [7:0]     period_counter_next;
    logic [7:0]     period_limit_reg;
    ptpwm_ctrl_type timer_control_reg;
    ptpwm_unit_type pwm_unit_control_reg;
    logic [7:0]     duty_low_byte_reg;
    logic [7:0]     duty_shadow_byte_reg;
    logic [1:0]     duty_latch_reg;
    logic [3:0]     post_reg;
    logic [3:0]     post_next;
    logic [7:0]     peripheral_flags_1_reg;
    logic [7:0]     peripheral_flags_1_next;
    logic [7:0]     irq_mask_reg;
    logic [7:0]     rdata_reg;
    logic           match_pulse_reg;
    logic           pin_reg;
    logic           pin_next;

    logic           wr_counter;
    logic           wr_limit;
    logic           wr_control;
    logic           wr_duty_low;
    logic           wr_pwm_ctl;
    logic           wr_shadow;
    logic           wr_mask;
    logic           rd_flags;
    logic           scale_clear;
    logic           tick;
    logic [1:0]     frac;
    logic           period_match;
    logic           post_event;
    logic           pwm_mode;
    logic [9:0]     duty_next;
    logic [9:0]     duty_live;
    logic [9:0]     time_live;
    logic [7:0]     rdata_next;

    // ------------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------------
    always_comb
    begin
        wr_counter  = 1'b0;
        wr_limit    = 1'b0;
        wr_control  = 1'b0;
        wr_duty_low = 1'b0;
        wr_pwm_ctl  = 1'b0;
        wr_shadow   = 1'b0;
        wr_mask     = 1'b0;
        if (bus_i.wr)
        begin
            if (bus_i.addr == OFS_COUNTER)
                wr_counter = 1'b1;
            else if (bus_i.addr == OFS_LIMIT)
                wr_limit = 1'b1;
            else if (bus_i.addr == OFS_CONTROL)
                wr_control = 1'b1;
            else if (bus_i.addr == OFS_DUTY_LOW)
                wr_duty_low = 1'b1;
            else if (bus_i.addr == OFS_PWM_CTL)
                wr_pwm_ctl = 1'b1;
            else if (bus_i.addr == OFS_SHADOW)
                wr_shadow = 1'b1;
            else if (bus_i.addr == OFS_MASK)
                wr_mask = 1'b1;
        end
    end

    assign rd_flags    = bus_i.rd && (bus_i.addr == OFS_FLAGS);
    assign scale_clear = wr_counter || wr_control;      // see R7

    // PWM mode selects the timer as its period time base
    assign pwm_mode =
        (pwm_unit_control_reg.mode_hi == PWM_MODE_CODE); // see R10

    // ------------------------------------------------------------------
    // prescaler and quarter-cycle phase
    // ------------------------------------------------------------------
    ptpwm_prescale u_prescale
    (
        .clock_i  (clock_i),
        .nrst_i   (nrst_i),
        .clear_i  (scale_clear),
        .run_i    (timer_control_reg.timer_run),        // see R9
        .select_i (timer_control_reg.prescale_select),  // see R2
        .tick_o   (tick),
        .frac_o   (frac)
    );

    // ------------------------------------------------------------------
    // period counter
    // ------------------------------------------------------------------
    // a software write beats a tick in the same cycle, so a write never
    // produces a stray match pulse
    always_comb
    begin
        period_counter_next = period_counter_reg;
        period_match        = 1'b0;
        if (wr_counter)
            period_counter_next = bus_i.wdata;          // see R6
        else if (tick)
        begin
            if (period_counter_reg == period_limit_reg)
            begin
                period_counter_next = COUNTER_RESET;    // see R15
                period_match        = 1'b1;
            end
            else
                period_counter_next = period_counter_reg + 8'h01; // see R15
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            period_counter_reg <= COUNTER_RESET;        // see R5
        else
            period_counter_reg <= period_counter_next;  // see R8
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            period_limit_reg <= LIMIT_RESET;            // see R5
        else if (wr_limit)
            period_limit_reg <= bus_i.wdata;            // see R6
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            timer_control_reg <= CONTROL_RESET;
        else if (wr_control)
            timer_control_reg <= bus_i.wdata & CONTROL_MASK; // see R9
    end

    // ------------------------------------------------------------------
    // postscaler
    // ------------------------------------------------------------------
    always_comb
    begin
        post_next  = post_reg;
        post_event = 1'b0;
        if (scale_clear)
            post_next = SCALE_RESET;                    // see R7
        else if (period_match)
        begin
            if (post_reg >= timer_control_reg.postscale_select) // see R4
            begin
                post_next  = SCALE_RESET;
                post_event = 1'b1;                      // see R3
            end
            else
                post_next = post_reg + 4'h1;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            post_reg <= SCALE_RESET;                    // see R7
        else
            post_reg <= post_next;
    end

    // raw match pulse for neighbours that clock from the timer output
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            match_pulse_reg <= 1'b0;
        else
            match_pulse_reg <= period_match;
    end

    // ------------------------------------------------------------------
    // interrupt flag and mask
    // ------------------------------------------------------------------
    // read clears; a terminal count in the same cycle still lands
    always_comb
    begin
        peripheral_flags_1_next = peripheral_flags_1_reg;
        if (rd_flags)
            peripheral_flags_1_next = FLAGS_RESET;
        if (post_event)
            peripheral_flags_1_next[FLAG_MATCH_BIT] = 1'b1; // see R3
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            peripheral_flags_1_reg <= FLAGS_RESET;
        else
            peripheral_flags_1_reg <= peripheral_flags_1_next & FLAGS_MASK;
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            irq_mask_reg <= MASK_RESET;
        else if (wr_mask)
            irq_mask_reg <= bus_i.wdata & FLAGS_MASK;
    end

    assign irq_o = |(peripheral_flags_1_reg & irq_mask_reg);

    // ------------------------------------------------------------------
    // PWM duty buffering
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            duty_low_byte_reg <= DUTY_RESET;
        else if (wr_duty_low)
            duty_low_byte_reg <= bus_i.wdata;
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pwm_unit_control_reg <= PWM_CTL_RESET;
        else if (wr_pwm_ctl)
            pwm_unit_control_reg <= bus_i.wdata & PWM_CTL_MASK;
    end

    assign duty_next = {duty_low_byte_reg,
                        pwm_unit_control_reg.duty_fraction_bit_hi,
                        pwm_unit_control_reg.duty_fraction_bit_lo};

    // shadow is only taken at a period boundary in PWM mode, so a duty written
    // mid-period never reaches the comparator before the next period starts
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            duty_shadow_byte_reg <= DUTY_RESET;
            duty_latch_reg       <= FRAC_RESET;
        end
        else if (pwm_mode && period_match)
        begin
            duty_shadow_byte_reg <= duty_next[9:2];     // see R11
            duty_latch_reg       <= duty_next[1:0];     // see R16
        end
        else if (!pwm_mode && wr_shadow)
            duty_shadow_byte_reg <= bus_i.wdata;
    end

    assign duty_live = {duty_shadow_byte_reg, duty_latch_reg};
    assign time_live = {period_counter_reg, frac};      // see R12

    // ------------------------------------------------------------------
    // PWM pin
    // ------------------------------------------------------------------
    // a duty longer than the period never matches, so the pin stays high;
    // set lags the wrap by one cycle like the clear lags the compare, so
    // the high time equals the duty count exactly
    always_comb
    begin
        pin_next = pin_reg;
        if (!pwm_mode)
            pin_next = 1'b0;
        else if (match_pulse_reg)
            pin_next = (duty_live != 10'h000);          // see R16
        else if (duty_live == time_live)
            pin_next = 1'b0;                            // see R12 R13
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pin_reg <= 1'b0;
        else
            pin_reg <= pin_next;
    end

    // ------------------------------------------------------------------
    // read data, one cycle after the read strobe
    // ------------------------------------------------------------------
    always_comb
    begin
        rdata_next = 8'h00;
        if (bus_i.addr == OFS_COUNTER)
            rdata_next = period_counter_reg;            // see R6
        else if (bus_i.addr == OFS_LIMIT)
            rdata_next = period_limit_reg;              // see R6
        else if (bus_i.addr == OFS_CONTROL)
            rdata_next = timer_control_reg & CONTROL_MASK; // see R9
        else if (bus_i.addr == OFS_DUTY_LOW)
            rdata_next = duty_low_byte_reg;
        else if (bus_i.addr == OFS_PWM_CTL)
            rdata_next = pwm_unit_control_reg & PWM_CTL_MASK;
        else if (bus_i.addr == OFS_SHADOW)
            rdata_next = duty_shadow_byte_reg;
        else if (bus_i.addr == OFS_FLAGS)
            rdata_next = peripheral_flags_1_reg;
        else if (bus_i.addr == OFS_MASK)
            rdata_next = irq_mask_reg;
    end

    // holds until the next read; the master samples it only once
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rdata_reg <= 8'h00;
        else if (bus_i.rd)
            rdata_reg <= rdata_next;
    end

    assign rdata_o          = rdata_reg;
    assign match_pulse_o    = match_pulse_reg;
    assign pwm_output_pin_o = pin_reg;
    assign pwm_mode_o       = pwm_mode;

endmodule

`default_nettype wire

// [ptpwm_timer_asserts.sv]
/*
 * Port-level checks for the period timer and PWM time base.
 * Assumes one clock and a master holding each strobe for one cycle.
 */
`timescale 1ns/1ns
`default_nettype none

module ptpwm_timer_asserts
    import ptpwm_pkg::*;
(
    input  wire logic          clock_i,
    input  wire logic          nrst_i,
    input  wire ptpwm_bus_type bus_i,
    input  wire logic [7:0]    rdata_o,
    input  wire logic          irq_o,
    input  wire logic          match_pulse_o,
    input  wire logic          pwm_output_pin_o,
    input  wire logic          pwm_mode_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    function automatic logic rd_at(input ptpwm_bus_type b,
                                   input logic [2:0]    a);
        return b.rd && b.addr == a;
    endfunction

    function automatic logic wr_at(input ptpwm_bus_type b,
                                   input logic [2:0]    a);
        return b.wr && b.addr == a;
    endfunction

    ctrl_top_zero_a: assert property (rd_at(bus_i, OFS_CONTROL)
        |=> rdata_o[7] == 1'b0) else $error("control bit 7 read as one");
    limit_readback_a: assert property (wr_at(bus_i, OFS_LIMIT)
        ##2 rd_at(bus_i, OFS_LIMIT) |=> rdata_o == $past(bus_i.wdata, 3))
        else $error("period limit read back wrong");
    ctrl_readback_a: assert property (wr_at(bus_i, OFS_CONTROL)
        ##2 rd_at(bus_i, OFS_CONTROL)
        |=> rdata_o == ($past(bus_i.wdata, 3) & CONTROL_MASK))
        else $error("control read back wrong");
    match_gap_a: assert property (match_pulse_o
        |=> !match_pulse_o [*3]) else $error("match pulses too close");
    pin_rise_match_a: assert property ($rose(pwm_output_pin_o)
        |-> $past(match_pulse_o))
        else $error("pin rose away from a period match");
    idle_pin_low_a: assert property (!pwm_mode_o
        |=> !pwm_output_pin_o) else $error("pin high outside pwm mode");
    mode_decode_a: assert property (wr_at(bus_i, OFS_PWM_CTL)
        |=> pwm_mode_o == ($past(bus_i.wdata[3:2]) == PWM_MODE_CODE))
        else $error("pwm mode decode wrong");
    flag_bits_a: assert property (rd_at(bus_i, OFS_FLAGS)
        |=> (rdata_o & ~FLAGS_MASK) == 8'h00)
        else $error("flag spare bits set");
    irq_cause_a: assert property ($rose(irq_o)
        |-> match_pulse_o || $past(match_pulse_o) || $past(bus_i.wr))
        else $error("irq rose without a match or a write");

    cover property ($rose(pwm_output_pin_o));
    cover property ($rose(irq_o));
    cover property (match_pulse_o && pwm_mode_o);
endmodule

bind ptpwm_timer ptpwm_timer_asserts ptpwm_timer_asserts_i (
    .clock_i          (clock_i),
    .nrst_i           (nrst_i),
    .bus_i            (bus_i),
    .rdata_o          (rdata_o),
    .irq_o            (irq_o),
    .match_pulse_o    (match_pulse_o),
    .pwm_output_pin_o (pwm_output_pin_o),
    .pwm_mode_o       (pwm_mode_o)
);

`default_nettype wire

// [tb.sv]
/*
 * Self-checking bench for the period timer and PWM time base.
 * Assumes the package register offsets and a 25 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none

module tb;
    import ptpwm_pkg::*;

    logic          clock_i;
    logic          nrst_i;
    ptpwm_bus_type bus_i;
    logic [7:0]    rdata_o;
    logic          irq_o;
    logic          match_pulse_o;
    logic          pin;
    logic          mode;
    int            err_count = 0;
    int            total_checks = 0;
    int            divs [4] = '{1, 4, 16, 16};

    ptpwm_timer ptpwm_timer_i (
        .clock_i          (clock_i),
        .nrst_i           (nrst_i),
        .bus_i            (bus_i),
        .rdata_o          (rdata_o),
        .irq_o            (irq_o),
        .match_pulse_o    (match_pulse_o),
        .pwm_output_pin_o (pin),
        .pwm_mode_o       (mode)
    );

    initial
    begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one idle cycle after each strobe keeps a single driver per time step
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock_i);
        bus_i <= '{1'b1, 1'b0, a, d};
        @(posedge clock_i);
        bus_i <= '0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock_i);
        bus_i <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clock_i);
        bus_i <= '0;
        @(posedge clock_i);
        d = rdata_o;
    endtask

    task automatic rdchk(input logic [2:0] a, input logic [7:0] exp,
                         input string what);
        logic [7:0] d;
        rd(a, d);
        check(what, {8'h00, d}, {8'h00, exp});
    endtask

    // cycles between two match pulses
    task automatic per(output int n);
        int g;
        g = 0;
        while (match_pulse_o !== 1'b1 && g < 3000)
        begin
            @(posedge clock_i);
            g++;
        end
        @(posedge clock_i);
        n = 1;
        while (match_pulse_o !== 1'b1 && n < 3000)
        begin
            @(posedge clock_i);
            n++;
        end
    endtask

    initial
    begin
        #(40 * 40000);
        err_count++;
        test_done();
    end

    initial
    begin
        logic [7:0] d;
        int         lim;
        int         n;
        int         g;
        int         p;
        int         hi;
        int         plen;
        int         duties [4];
        nrst_i = 1'b0;
        bus_i = '0;
        void'($urandom(13));
        repeat (10) @(posedge clock_i);
        nrst_i <= 1'b1;
        rdchk(OFS_COUNTER, 8'h00, "counter");
        rdchk(OFS_LIMIT, 8'hFF, "limit");
        rdchk(OFS_FLAGS, 8'h00, "flags");
        wr(OFS_CONTROL, 8'hFB);
        rdchk(OFS_CONTROL, 8'h7B, "control");
        wr(OFS_FLAGS, 8'hFF);
        rdchk(OFS_FLAGS, 8'h00, "flags");
        d = 8'($urandom_range(0, 255));
        wr(OFS_COUNTER, d);
        rdchk(OFS_COUNTER, d, "counter");
        wr(OFS_CONTROL, 8'h30);
        rdchk(OFS_COUNTER, d, "counter");
        for (int c = 0; c < 4; c++)
        begin
            lim = $urandom_range(1, 5);
            wr(OFS_LIMIT, 8'(lim));
            rdchk(OFS_LIMIT, 8'(lim), "limit");
            wr(OFS_COUNTER, 8'h00);
            wr(OFS_CONTROL, 8'(4 + c));
            per(n);
            check("period", 16'(n), 16'((lim + 1) * 4 * divs[c]));
        end
        wr(OFS_LIMIT, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            p = (i == 3) ? 15 : (i == 2) ? $urandom_range(2, 14) : i;
            wr(OFS_CONTROL, 8'h00);
            wr(OFS_MASK, 8'h02);
            rd(OFS_FLAGS, d);
            wr(OFS_CONTROL, 8'(p * 8 + 4));
            n = 0;
            g = 0;
            while (irq_o !== 1'b1 && g < 2000)
            begin
                @(posedge clock_i);
                if (match_pulse_o === 1'b1)
                    n++;
                g++;
            end
            check("post", 16'(n), 16'(p + 1));
            wr(OFS_CONTROL, 8'h00);
            wr(OFS_MASK, 8'h00);
            @(posedge clock_i);
            check("irq", 16'(irq_o), 16'h0000);
            rdchk(OFS_FLAGS, 8'h02, "flags");
            rdchk(OFS_FLAGS, 8'h00, "flags");
        end
        // phase is free running, so the restart delay has a small spread
        wr(OFS_LIMIT, 8'h02);
        wr(OFS_CONTROL, 8'h06);
        repeat ($urandom_range(20, 90)) @(posedge clock_i);
        wr(OFS_COUNTER, 8'h02);
        n = 0;
        while (match_pulse_o !== 1'b1 && n < 200)
        begin
            @(posedge clock_i);
            n++;
        end
        check("restart", 16'(n >= 56 && n <= 70), 16'h0001);
        lim = $urandom_range(3, 15);
        plen = (lim + 1) * 4;
        duties = '{0, $urandom_range(1, plen - 1), plen, 1023};
        wr(OFS_LIMIT, 8'(lim));
        wr(OFS_COUNTER, 8'h00);
        wr(OFS_DUTY_LOW, 8'h00);
        wr(OFS_PWM_CTL, 8'h00);
        wr(OFS_CONTROL, 8'h04);
        foreach (duties[i])
        begin
            wr(OFS_DUTY_LOW, 8'(duties[i] >> 2));
            wr(OFS_PWM_CTL, 8'(((duties[i] & 3) << 4) | 12));
            per(n);
            per(n);
            check("mode", 16'(mode), 16'h0001);
            rdchk(OFS_SHADOW, 8'(duties[i] >> 2), "shadow");
            hi = 0;
            repeat (plen)
            begin
                @(posedge clock_i);
                if (pin === 1'b1)
                    hi++;
            end
            check("high", 16'(hi),
                  16'(duties[i] < plen ? duties[i] : plen));
        end
        wr(OFS_PWM_CTL, 8'h00);
        repeat (2) @(posedge clock_i);
        check("pin", 16'(pin), 16'h0000);
        test_done();
    end
endmodule

`default_nettype wire
